// >>> design/amp_ctrl.sv
// startup, shutdown and protection sequencer of a four-half-bridge class-d stage
// Overview of operation
// - outputs stay high impedance until gate-drive and common supplies exceed undervoltage levels
// - weak pulldown on every half-bridge output while reset pin is low and bridges are not switching, except in single-ended
// - each ramp lasts 100 ms plus one ms per nF of ramp capacitor
// - grounded input with unfitted bootstrap never switches; codes 000, 001 drop ab, cd
// - a protection fault puts affected stage high impedance and pulls fault flag low
// - faults except overload and thermal shutdown recover by themselves once cleared
// - a or b fault stops a+b, c or d stops c+d; parallel stops all
// - bootstrap undervoltage only turns off that half-bridge high side
// - short probe runs only at supply startup, never later
// - found short holds all bridges high impedance until removed, then startup continues
// - probe checks shorts to ground first, then shorts to power supply
// - probe step length scales with filter capacitance, 15 ms per uF
// - during probe fault flag held low and reset ignored; released when clean
// - reset pin never starts a new short probe
// - short probe enabled in bridge-tied and parallel, skipped in single-ended
// - warning flag low above 125 C, released below hysteresis level
// - above 155 C all bridges off, fault flag low, condition latched
// - latched thermal shutdown cleared only by reset pin, then normal operation
// - outside the short probe, reset pin low forces fault flag released regardless of faults
// - global latched faults need a reset pin toggle to clear
`timescale 1ns/1ns
`include "amp_params.svh"

module amp_ctrl #(
  parameter int unsigned MS_CYC = `AMP_MS_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        amp_reset_n_i,
  input  wire logic        gate_drive_supply_ok_i,
  input  wire logic        common_supply_ok_i,
  input  wire logic        power_stage_supply_ok_i,
  input  wire logic [3:0]  bootstrap_node_ok_i,
  input  wire logic [3:0]  overcurrent_guard_i,
  input  wire logic [3:0]  overload_shutdown_i,
  input  wire logic        temp_warn_i,
  input  wire logic        temp_shutdown_i,
  input  wire logic [3:0]  short_gnd_i,
  input  wire logic [3:0]  short_pwr_i,
  input  wire logic [2:0]  mode_i,
  input  wire logic [10:0] ramp_timing_capacitor_nf_i,
  input  wire logic [3:0]  filter_cap_uf_i,
  output logic      [3:0]  bridge_en_o,
  output logic      [3:0]  hs_en_o,
  output logic      [3:0]  pulldown_en_o,
  output logic             probe_gnd_o,
  output logic             probe_pwr_o,
  output logic             ramp_active_o,
  output logic             fault_n_o,
  output logic             fault_n_oe_o,
  output logic             overtemp_warning_n_o,
  output logic             overtemp_warning_n_oe_o,
  output logic             thermal_shutdown_latch_o
);

  // synchronised pin images
  logic                    rst_pin;
  logic                    gate_ok;
  logic                    common_ok;
  logic                    power_ok;
  logic [3:0]              boot_ok;
  logic [3:0]              oc_flt;
  logic [3:0]              ovl_flt;
  logic                    warn_hot;
  logic                    shut_hot;
  logic [3:0]              sh_gnd;
  logic [3:0]              sh_pwr;
  logic [2:0]              mode;
  logic [10:0]             cap_nf;
  logic [3:0]              filt_uf;

  amp_pin_if pin_bus ();

  assign pin_bus.raw = {amp_reset_n_i, gate_drive_supply_ok_i, common_supply_ok_i, power_stage_supply_ok_i,
                        bootstrap_node_ok_i, overcurrent_guard_i, overload_shutdown_i, temp_warn_i,
                        temp_shutdown_i, short_gnd_i, short_pwr_i, mode_i, ramp_timing_capacitor_nf_i,
                        filter_cap_uf_i};
  assign {rst_pin, gate_ok, common_ok, power_ok, boot_ok, oc_flt, ovl_flt, warn_hot,
          shut_hot, sh_gnd, sh_pwr, mode, cap_nf, filt_uf} = pin_bus.clean;

  amp_pin_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .pins      (pin_bus.sync)
  );

  // state and latches
  amp_pkg::amp_state_t     st_q;
  amp_pkg::amp_state_t     st_d;
  amp_pkg::amp_cfg_t       cfg;
  logic                    probe_done_q;
  logic                    therm_q;
  logic [3:0]              ovl_q;
  logic [`AMP_MS_DIV_W-1:0] ms_div_q;
  logic [`AMP_MS_CNT_W-1:0] ms_cnt_q;
  logic                    ms_tick;
  logic [`AMP_MS_CNT_W-1:0] ramp_ms;
  logic [`AMP_MS_CNT_W-1:0] probe_ms;
  logic                    ramp_done;
  logic                    step_done;
  logic                    uv;
  logic                    running;
  logic                    probing;
  logic [3:0]              chan_f;
  logic [3:0]              off_mask;
  logic [3:0]              unused_mask;
  logic [3:0]              bridge_d;
  logic                    fault_low;

  // supply guard: any monitored supply low is a self-clearing global fault
  assign uv = !gate_ok || !common_ok || !power_ok;

  // output configuration decode from the mode pins
  always_comb begin
    if (mode == `AMP_MODE_SE) begin
      cfg = amp_pkg::AMP_CFG_SE;
    end else if (mode == `AMP_MODE_PARALLEL_BRIDGE_CONFIG) begin
      cfg = amp_pkg::AMP_CFG_PARALLEL_BRIDGE_CONFIG;
    end else begin
      cfg = amp_pkg::AMP_CFG_BTL;
    end
  end

  // channels dropped by the mode code never switch
  always_comb begin
    if (mode == `AMP_MODE_UNUSED_AB) begin
      unused_mask = `AMP_MASK_AB;
    end else if (mode == `AMP_MODE_UNUSED_CD) begin
      unused_mask = `AMP_MASK_CD;
    end else begin
      unused_mask = `AMP_MASK_NONE;
    end
  end

  // ramp is base time plus one ms per nF; probe step 15 ms per uF, at least 1 ms
  assign ramp_ms  = `AMP_RAMP_BASE_MS + `AMP_RAMP_MS_PER_NF * {1'b0, cap_nf};
  assign probe_ms = (filt_uf == 4'h0) ? `AMP_PROBE_MIN_MS
                                      : 12'(`AMP_PROBE_MS_PER_UF * {8'h00, filt_uf});
  assign ramp_done = (ms_cnt_q == ramp_ms);
  assign step_done = (ms_cnt_q == probe_ms);
  assign ms_tick   = (ms_div_q == `AMP_MS_DIV_W'(MS_CYC - 1));

  // millisecond base and per-state elapsed count, restarted on every state change
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || st_d != st_q) begin
      ms_div_q <= '0;
      ms_cnt_q <= '0;
    end else if (ms_tick) begin
      ms_div_q <= '0;
      ms_cnt_q <= ms_cnt_q + 12'h001;
    end else begin
      ms_div_q <= ms_div_q + `AMP_MS_DIV_W'(1);
    end
  end

  // sequencer next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      amp_pkg::AMP_ST_OFF: begin
        if (!uv) begin
          // probe only once per common-supply power-up, never in single-ended
          st_d = (!probe_done_q && cfg != amp_pkg::AMP_CFG_SE) ? amp_pkg::AMP_ST_PROBE_GND
                                                              : amp_pkg::AMP_ST_RST_WAIT;
        end
      end
      amp_pkg::AMP_ST_PROBE_GND: begin
        // reset pin not looked at while probing
        if (!common_ok) begin
          st_d = amp_pkg::AMP_ST_OFF;
        end else if (step_done) begin
          st_d = (sh_gnd != 4'h0) ? amp_pkg::AMP_ST_SHORT_HOLD : amp_pkg::AMP_ST_PROBE_PWR;
        end
      end
      amp_pkg::AMP_ST_PROBE_PWR: begin
        if (!common_ok) begin
          st_d = amp_pkg::AMP_ST_OFF;
        end else if (step_done) begin
          st_d = (sh_pwr != 4'h0) ? amp_pkg::AMP_ST_SHORT_HOLD : amp_pkg::AMP_ST_RST_WAIT;
        end
      end
      amp_pkg::AMP_ST_SHORT_HOLD: begin
        if (!common_ok) begin
          st_d = amp_pkg::AMP_ST_OFF;
        end else if (sh_gnd == 4'h0 && sh_pwr == 4'h0) begin
          st_d = amp_pkg::AMP_ST_RST_WAIT;
        end
      end
      amp_pkg::AMP_ST_RST_WAIT: begin
        if (!common_ok) begin
          st_d = amp_pkg::AMP_ST_OFF;
        end else if (rst_pin && !therm_q && !uv) begin
          st_d = amp_pkg::AMP_ST_RAMP_UP;
        end
      end
      amp_pkg::AMP_ST_RAMP_UP: begin
        if (!common_ok) begin
          st_d = amp_pkg::AMP_ST_OFF;
        end else if (therm_q) begin
          st_d = amp_pkg::AMP_ST_RST_WAIT;
        end else if (!rst_pin) begin
          st_d = amp_pkg::AMP_ST_RAMP_DN;
        end else if (ramp_done) begin
          st_d = amp_pkg::AMP_ST_RUN;
        end
      end
      amp_pkg::AMP_ST_RUN: begin
        if (!common_ok) begin
          st_d = amp_pkg::AMP_ST_OFF;
        end else if (therm_q) begin
          st_d = amp_pkg::AMP_ST_RST_WAIT;
        end else if (!rst_pin) begin
          st_d = amp_pkg::AMP_ST_RAMP_DN;
        end
      end
      amp_pkg::AMP_ST_RAMP_DN: begin
        if (!common_ok) begin
          st_d = amp_pkg::AMP_ST_OFF;
        end else if (therm_q || ramp_done) begin
          st_d = amp_pkg::AMP_ST_RST_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      st_q <= amp_pkg::AMP_ST_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // probe-done memory: only a loss of common supply rearms it, the reset pin does not
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || !common_ok) begin
      probe_done_q <= 1'b0;
    end else if (st_q == amp_pkg::AMP_ST_RST_WAIT) begin
      probe_done_q <= 1'b1;
    end
  end

  // thermal and overload latches; a new event wins over the clear by reset pin
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      therm_q <= 1'b0;
      ovl_q   <= 4'h0;
    end else begin
      therm_q <= shut_hot || (therm_q && rst_pin);
      ovl_q   <= ovl_flt | (ovl_q & {4{rst_pin}});
    end
  end

  // channel fault grouping by output configuration
  assign chan_f = oc_flt | ovl_q;
  always_comb begin
    if (cfg == amp_pkg::AMP_CFG_PARALLEL_BRIDGE_CONFIG) begin
      off_mask = (chan_f != 4'h0) ? `AMP_MASK_ALL : `AMP_MASK_NONE;
    end else begin
      off_mask = ((chan_f & `AMP_MASK_AB) != 4'h0 ? `AMP_MASK_AB : `AMP_MASK_NONE)
               | ((chan_f & `AMP_MASK_CD) != 4'h0 ? `AMP_MASK_CD : `AMP_MASK_NONE);
    end
  end

  assign running = (st_q == amp_pkg::AMP_ST_RAMP_UP) || (st_q == amp_pkg::AMP_ST_RUN)
                || (st_q == amp_pkg::AMP_ST_RAMP_DN);
  assign probing = (st_q == amp_pkg::AMP_ST_PROBE_GND) || (st_q == amp_pkg::AMP_ST_PROBE_PWR)
                || (st_q == amp_pkg::AMP_ST_SHORT_HOLD);

  // switching allowed only in the ramp and run states with no fault on the group
  assign bridge_d = (running && !uv && !therm_q) ? ~(off_mask | unused_mask) : `AMP_MASK_NONE;

  // bridge enables; bootstrap loss only drops the high side of that half-bridge
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      bridge_en_o <= `AMP_RST_BRIDGE;
      hs_en_o     <= `AMP_RST_BRIDGE;
    end else begin
      bridge_en_o <= bridge_d;
      hs_en_o     <= bridge_d & boot_ok;
    end
  end

  // weak pulldown charges bootstraps; kept off while switching and in single-ended
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pulldown_en_o <= `AMP_MASK_NONE;
    end else begin
      pulldown_en_o <= (!rst_pin && !running && cfg != amp_pkg::AMP_CFG_SE) ? `AMP_MASK_ALL
                                                                            : `AMP_MASK_NONE;
    end
  end

  // probe drives and ramp status
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      probe_gnd_o   <= 1'b0;
      probe_pwr_o   <= 1'b0;
      ramp_active_o <= 1'b0;
    end else begin
      probe_gnd_o   <= (st_q == amp_pkg::AMP_ST_PROBE_GND) || (st_q == amp_pkg::AMP_ST_SHORT_HOLD);
      probe_pwr_o   <= (st_q == amp_pkg::AMP_ST_PROBE_PWR) || (st_q == amp_pkg::AMP_ST_SHORT_HOLD);
      ramp_active_o <= (st_q == amp_pkg::AMP_ST_RAMP_UP) || (st_q == amp_pkg::AMP_ST_RAMP_DN);
    end
  end

  // fault flag: probe holds it low even with reset low; otherwise reset low releases it
  assign fault_low = probing || (rst_pin && (uv || therm_q || chan_f != 4'h0));

  // open-drain flags: output level always low, enable pulls the line
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      fault_n_oe_o            <= `AMP_RST_FLAG_OE;
      overtemp_warning_n_oe_o <= `AMP_RST_FLAG_OE;
      thermal_shutdown_latch_o <= 1'b0;
      fault_n_o               <= 1'b0;
      overtemp_warning_n_o    <= 1'b0;
    end else begin
      fault_n_oe_o            <= fault_low;
      overtemp_warning_n_oe_o <= warn_hot;
      thermal_shutdown_latch_o <= therm_q;
      fault_n_o               <= 1'b0;
      overtemp_warning_n_o    <= 1'b0;
    end
  end

  // checks
  property p_uv_hiz;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (gate_ok == 1'b0 || common_ok == 1'b0) |=> (bridge_en_o == 4'h0);
  endproperty
  a_uv_hiz: assert property (p_uv_hiz) else $error("bridge enabled under undervoltage");

  property p_pulldown;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (!rst_pin && !running && cfg == amp_pkg::AMP_CFG_BTL) |=> (pulldown_en_o == 4'hF);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pulldown missing while reset low");

  property p_ramp_len;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (st_q == amp_pkg::AMP_ST_RAMP_UP && st_d == amp_pkg::AMP_ST_RUN) |-> (ms_cnt_q == ramp_ms);
  endproperty
  a_ramp_len: assert property (p_ramp_len) else $error("ramp ended at wrong length");

  property p_fault_flag;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (rst_pin && oc_flt != 4'h0) |=> fault_n_oe_o ##0 (bridge_en_o != 4'hF);
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("channel fault not reported");

  property p_parallel_bridge_config_all;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (cfg == amp_pkg::AMP_CFG_PARALLEL_BRIDGE_CONFIG && oc_flt != 4'h0) |=> (bridge_en_o == 4'h0);
  endproperty
  a_parallel_bridge_config_all: assert property (p_parallel_bridge_config_all) else $error("parallel fault left a bridge on");

  property p_boot_hs;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (!boot_ok[0]) |=> (!hs_en_o[0] && bridge_en_o[0] == $past(bridge_d[0]));
  endproperty
  a_boot_hs: assert property (p_boot_hs) else $error("bootstrap loss misapplied");

  property p_no_late_probe;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (st_q == amp_pkg::AMP_ST_RUN) |=> (st_q != amp_pkg::AMP_ST_PROBE_GND);
  endproperty
  a_no_late_probe: assert property (p_no_late_probe) else $error("probe after startup");

  property p_probe_order;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (st_q == amp_pkg::AMP_ST_PROBE_PWR) |-> ($past(st_q) == amp_pkg::AMP_ST_PROBE_GND
                                          || $past(st_q) == amp_pkg::AMP_ST_PROBE_PWR);
  endproperty
  a_probe_order: assert property (p_probe_order) else $error("probe steps out of order");

  property p_probe_flag;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (probing && !rst_pin) |=> fault_n_oe_o;
  endproperty
  a_probe_flag: assert property (p_probe_flag) else $error("fault flag released during probe");

  property p_se_skip;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (st_q == amp_pkg::AMP_ST_OFF && cfg == amp_pkg::AMP_CFG_SE) |=> (st_q != amp_pkg::AMP_ST_PROBE_GND);
  endproperty
  a_se_skip: assert property (p_se_skip) else $error("probe run in single-ended");

  property p_therm_hold;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (therm_q && rst_pin) |=> therm_q ##0 (bridge_en_o == 4'h0);
  endproperty
  a_therm_hold: assert property (p_therm_hold) else $error("thermal latch lost");

  property p_rst_release;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (!rst_pin && !probing) |=> !fault_n_oe_o;
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("fault flag low while reset low");

  property p_ramp_down;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (st_q == amp_pkg::AMP_ST_RUN && !rst_pin && common_ok && !therm_q) |=> (st_q == amp_pkg::AMP_ST_RAMP_DN);
  endproperty
  a_ramp_down: assert property (p_ramp_down) else $error("no shutdown ramp on reset");

endmodule

// >>> design/amp_params.svh
// constants of the class-d output stage startup and protection controller
`ifndef AMP_PARAMS_SVH
`define AMP_PARAMS_SVH

// clock and time base
`define AMP_CLK_HZ            125000000
`define AMP_MS_CYC            (`AMP_CLK_HZ / 1000)
`define AMP_MS_DIV_W          17

// ramp and short-probe timing, in milliseconds
`define AMP_MS_CNT_W          12
`define AMP_RAMP_BASE_MS      12'h064
`define AMP_RAMP_MS_PER_NF    12'h001
`define AMP_PROBE_MS_PER_UF   12'h00F
`define AMP_PROBE_MIN_MS      12'h001

// config pin codes
`define AMP_MODE_UNUSED_AB    3'h0
`define AMP_MODE_UNUSED_CD    3'h1
`define AMP_MODE_PARALLEL_BRIDGE_CONFIG         3'h3
`define AMP_MODE_SE           3'h5

// half-bridge masks, bit 0 is channel a
`define AMP_MASK_AB           4'h3
`define AMP_MASK_CD           4'hC
`define AMP_MASK_NONE         4'h0
`define AMP_MASK_ALL          4'hF

// synchronised pin bundle width
`define AMP_SYN_W             44

// reset values of outputs
`define AMP_RST_BRIDGE        4'h0
`define AMP_RST_FLAG_OE       1'h0

`endif

// >>> design/amp_pkg.sv
// types of the class-d output stage startup and protection controller
package amp_pkg;

  // gray codes along off, probe, wait, ramp up, run, ramp down
  typedef enum logic [2:0] {
    AMP_ST_OFF        = 3'h0,
    AMP_ST_PROBE_GND  = 3'h1,
    AMP_ST_PROBE_PWR  = 3'h3,
    AMP_ST_RST_WAIT   = 3'h2,
    AMP_ST_RAMP_UP    = 3'h6,
    AMP_ST_RUN        = 3'h7,
    AMP_ST_RAMP_DN    = 3'h5,
    AMP_ST_SHORT_HOLD = 3'h4
  } amp_state_t;

  typedef enum logic [1:0] {
    AMP_CFG_BTL  = 2'h0,
    AMP_CFG_PARALLEL_BRIDGE_CONFIG = 2'h1,
    AMP_CFG_SE   = 2'h2
  } amp_cfg_t;

endpackage

// >>> design/amp_pin_if.sv
// pin bundle carried between the controller and its input synchroniser
`timescale 1ns/1ns
`include "amp_params.svh"

interface amp_pin_if;
  logic [`AMP_SYN_W-1:0] raw;
  logic [`AMP_SYN_W-1:0] clean;

  modport ctrl (output raw, input clean);
  modport sync (input raw, output clean);
endinterface

// >>> design/amp_pin_sync.sv
// three-stage input synchroniser with agreement filter per pin
`timescale 1ns/1ns
`include "amp_params.svh"

module amp_pin_sync (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  amp_pin_if.sync   pins
);

  genvar gi;
  generate
    for (gi = 0; gi < `AMP_SYN_W; gi++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic clean_q;
      // first stage feeds only the second; a change counts once stages two and three agree
      always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
          s1_q    <= 1'b0;
          s2_q    <= 1'b0;
          s3_q    <= 1'b0;
          clean_q <= 1'b0;
        end else begin
          s1_q <= pins.raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            clean_q <= s3_q;
          end
        end
      end
      assign pins.clean[gi] = clean_q;
    end
  endgenerate

endmodule

// >>> sim/amp_ctl_model.sv
// behavioural system controller that owns the device reset pin
`timescale 1ns/1ns

module amp_ctl_model #(
  parameter int unsigned SETTLE = 4
) (
  input  wire logic sys_clk_i,
  input  wire logic go_i,
  input  wire logic supplies_ok_i,
  output logic      amp_reset_n_o,
  output logic      idle_pwm_o
);
  logic [7:0] ok_cnt_q;

  // muted idle input at 50 percent duty; the bench does not connect it to the device
  always_ff @(posedge sys_clk_i) begin
    idle_pwm_o <= (idle_pwm_o === 1'b1) ? 1'b0 : 1'b1;
  end

  // count how long all supplies have stood on; a larger settle models a slow controller
  always_ff @(posedge sys_clk_i) begin
    ok_cnt_q <= !supplies_ok_i ? 8'h00 : (ok_cnt_q == SETTLE[7:0]) ? ok_cnt_q : ok_cnt_q + 8'h01;
  end

  // release only on settled supplies; once released, hold so a brownout is handled by the device alone
  always_ff @(posedge sys_clk_i) begin
    amp_reset_n_o <= go_i && (amp_reset_n_o || ok_cnt_q == SETTLE[7:0]);
  end
endmodule

// >>> sim/amp_stage_startup_protection_ctrl_tb_top.sv
// self-checking bench of the class-d startup and protection controller
`timescale 1ns/1ns

module amp_stage_startup_protection_ctrl_tb_top;
  localparam int unsigned MS = 10;
  localparam int CEIL = 20000;
  localparam logic [3:0] F = 4'hF;
  localparam logic [3:0] Z = 4'h0;
  localparam logic [17:0] MALL = 18'h3FFFF;
  typedef struct packed { logic [17:0] m; logic [17:0] v; } amp_note_t;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic go = 1'b0, gd_ok = 1'b0, cm_ok = 1'b0, ps_ok = 1'b0, t_warn = 1'b0, t_sd = 1'b0;
  logic [2:0] mode = 3'h2;
  logic [3:0] oc = 4'h0, bst = 4'hF, sh_gnd = 4'h0, br, hs, pd;
  logic [3:0] sh_pwr = 4'h0, ovl = 4'h0, filt = 4'h0;
  logic pwm_idle;
  logic [10:0] cap_nf = 11'h000;
  logic amp_rst_n, f_oe, w_oe, latch, pg, pp, ramp;
  logic [31:0] seed = 32'h1859730F;
  logic [2:0] md_t [7] = '{3'h2, 3'h2, 3'h2, 3'h3, 3'h5, 3'h0, 3'h1};
  logic [3:0] oc_t [7] = '{4'h0, 4'h2, 4'h8, 4'h1, 4'h4, 4'h0, 4'h0};
  logic [3:0] br_t [7] = '{4'hF, 4'hC, 4'h3, 4'h0, 4'h3, 4'hC, 4'h3};
  amp_note_t q[$];
  event chk_ev;
  int bad_count = 0, total_checks = 0, cyc = 0, rc;
  wire [17:0] obs = {br, hs, pd, f_oe, w_oe, latch, pg, pp, ramp};

  amp_ctl_model #(.SETTLE(4)) ctl_u (.sys_clk_i(sys_clk_i), .go_i(go),
    .supplies_ok_i(gd_ok & cm_ok & ps_ok), .amp_reset_n_o(amp_rst_n), .idle_pwm_o(pwm_idle));

  amp_ctrl #(.MS_CYC(MS)) dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .amp_reset_n_i(amp_rst_n),
    .gate_drive_supply_ok_i(gd_ok), .common_supply_ok_i(cm_ok), .power_stage_supply_ok_i(ps_ok),
    .bootstrap_node_ok_i(bst), .overcurrent_guard_i(oc), .overload_shutdown_i(ovl), .temp_warn_i(t_warn),
    .temp_shutdown_i(t_sd), .short_gnd_i(sh_gnd), .short_pwr_i(sh_pwr), .mode_i(mode),
    .ramp_timing_capacitor_nf_i(cap_nf), .filter_cap_uf_i(filt), .bridge_en_o(br), .hs_en_o(hs),
    .pulldown_en_o(pd), .probe_gnd_o(pg), .probe_pwr_o(pp), .ramp_active_o(ramp), .fault_n_o(),
    .fault_n_oe_o(f_oe), .overtemp_warning_n_o(), .overtemp_warning_n_oe_o(w_oe),
    .thermal_shutdown_latch_o(latch));

  // free-running clock
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [17:0] f(input logic [3:0] b, h, p, input logic [5:0] fl);
    return {b, h, p, fl};
  endfunction

  task automatic cw(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // driver side files the expected outputs; the watcher below compares them
  task automatic note(input logic [17:0] m, input logic [17:0] v);
    q.push_back('{m: m, v: v});
    -> chk_ev;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watcher: takes the oldest note and compares the masked outputs
  initial begin
    amp_note_t n;
    forever begin
      @(chk_ev);
      while (q.size() > 0) begin
        n = q.pop_front();
        total_checks++;
        if ((obs & n.m) !== (n.v & n.m)) begin
          bad_count++;
          $display("[FAIL] t=%0t got %h exp %h", $time, obs & n.m, n.v & n.m);
        end
      end
    end
  end

  // hang guard sized for three ramps of the largest random capacitor
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == CEIL) begin
      bad_count++;
      report_and_stop();
    end
  end

  // main sequence; ramp length follows the random capacitor value
  initial begin
    seed = xs(seed);
    cap_nf = {3'h0, seed[7:0]};
    rc = (100 + int'(seed[7:0])) * MS;
    cw(2);
    resetn_i = 1'b1;
    cw(8);
    note(MALL, f(Z, Z, F, 6'h00));
    sh_gnd = 4'h1;
    gd_ok = 1'b1;
    cm_ok = 1'b1;
    ps_ok = 1'b1;
    cw(9);
    note(MALL & ~f(Z, Z, F, 6'h00), f(Z, Z, Z, 6'h24));
    go = 1'b1;
    cw(16);
    note(f(F, Z, Z, 6'h07), f(Z, Z, Z, 6'h06));
    sh_gnd = 4'h0;
    cw(10);
    note(MALL, f(F, F, Z, 6'h01));
    cw(rc - 15);
    note(f(Z, Z, Z, 6'h01), f(Z, Z, Z, 6'h01));
    cw(30);
    note(MALL, f(F, F, Z, 6'h00));
    for (int i = 0; i < 7; i++) begin
      mode = md_t[i];
      oc = oc_t[i];
      cw(10);
      note(f(F, Z, Z, 6'h20), f(br_t[i], Z, Z, {oc_t[i] != 4'h0, 5'h00}));
    end
    mode = 3'h2;
    oc = 4'h0;
    bst = 4'hE;
    cw(10);
    note(MALL, f(F, 4'hE, Z, 6'h00));
    bst = 4'hF;
    gd_ok = 1'b0;
    cw(10);
    note(MALL, f(Z, Z, Z, 6'h20));
    gd_ok = 1'b1;
    t_warn = 1'b1;
    cw(10);
    note(MALL, f(F, F, Z, 6'h10));
    t_warn = 1'b0;
    t_sd = 1'b1;
    cw(10);
    note(f(F, Z, Z, 6'h38), f(Z, Z, Z, 6'h28));
    t_sd = 1'b0;
    cw(10);
    note(f(F, Z, Z, 6'h38), f(Z, Z, Z, 6'h28));
    go = 1'b0;
    cw(10);
    note(MALL, f(Z, Z, F, 6'h00));
    go = 1'b1;
    cw(10);
    note(MALL, f(F, F, Z, 6'h01));
    cw(rc + 20);
    // overload on channel a stays latched after its pin clears, while reset pin is high
    ovl = 4'h1;
    cw(10);
    ovl = 4'h0;
    cw(10);
    note(MALL, f(4'hC, 4'hC, Z, 6'h20));
    go = 1'b0;
    cw(10);
    note(f(Z, Z, Z, 6'h05), f(Z, Z, Z, 6'h01));
    cw(rc + 20);
    note(MALL, f(Z, Z, F, 6'h00));
    cm_ok = 1'b0;
    cw(10);
    mode = 3'h5;
    cm_ok = 1'b1;
    cw(9);
    note(MALL, f(Z, Z, Z, 6'h00));
    // fresh bridge-tied power-up, 1 uF filter: ground step, supply step, then hold on a supply short
    cm_ok = 1'b0;
    cw(10);
    mode = 3'h2;
    filt = 4'h1;
    sh_pwr = 4'h2;
    cm_ok = 1'b1;
    cw(20);
    note(f(F, Z, Z, 6'h27), f(Z, Z, Z, 6'h24));
    cw(150);
    note(f(F, Z, Z, 6'h27), f(Z, Z, Z, 6'h22));
    cw(150);
    note(f(F, Z, Z, 6'h27), f(Z, Z, Z, 6'h26));
    sh_pwr = 4'h0;
    cw(10);
    note(MALL, f(Z, Z, F, 6'h00));
    cw(1);
    report_and_stop();
  end
endmodule
